// ### logic/pvcsr_params.svh
// Purpose: Offsets, field positions, reset values and timing counts of the
//          10 Mbit/s control and quick-status management registers.
// Assumes: Included by bare name; definitions only.
// Notes:   Fixed PHY address applies to the embedded PHY.
`ifndef PVCSR_PARAMS_SVH
`define PVCSR_PARAMS_SVH

`define PVCSR_PHY_ADDR 5'h10
`define PVCSR_REG_TEN_MEG 5'h1E
`define PVCSR_REG_QUICK 5'h1F
`define PVCSR_OP_READ 2'h2
`define PVCSR_OP_WRITE 2'h1
`define PVCSR_ADDR_LAST 4'h9
`define PVCSR_DATA_LAST 4'hF
`define PVCSR_TA_LAST 4'h1

`define PVCSR_CTL_RESET 16'h0000
`define PVCSR_CTL_WMASK 16'hE07B
`define PVCSR_CTL_TONE 15
`define PVCSR_CTL_PWR_KEEP 14
`define PVCSR_CTL_JAB_OFF 13
`define PVCSR_CTL_ENH_LINK 6
`define PVCSR_CTL_HEARTBEAT 5
`define PVCSR_CTL_LONG_LINE 4
`define PVCSR_CTL_POL_OFF 3
`define PVCSR_CTL_SERIAL 1
`define PVCSR_CTL_NO_LP 0

`define PVCSR_QS_IRQ_SEL 7
`define PVCSR_QS_IRQ_MASK 6

`define PVCSR_SYS_CLK_MHZ 100
`define PVCSR_TONE_MHZ 10
`define PVCSR_TONE_HALF_CYC (`PVCSR_SYS_CLK_MHZ / (2 * `PVCSR_TONE_MHZ))

`endif

// ### logic/pvcsr_pkg.sv
// Purpose: Types shared by the management register bank and its serial slave.
// Assumes: Nothing is imported; users write pvcsr_pkg::name.
// Notes:   All state of each module lives in one packed struct.
package pvcsr_pkg;

	typedef enum logic [2:0] {
		MD_IDLE,
		MD_START,
		MD_OP,
		MD_ADDR,
		MD_TA,
		MD_DATA
	} pvcsr_md_state_t;

	typedef struct packed {
		logic mdc_s1;
		logic mdc_s2;
		logic mdc_d;
		logic mdio_s1;
		logic mdio_s2;
		pvcsr_md_state_t state;
		logic [3:0] cnt;
		logic [15:0] shreg;
		logic op_rd;
		logic match;
		logic mdio_out;
		logic oe_n;
		logic rd_stb;
		logic wr_stb;
		logic [4:0] addr;
		logic [15:0] wdata;
	} pvcsr_md_t;

	typedef struct packed {
		logic [1:0] enh_sync;
		logic [15:0] ctl;
		logic rx_err;
		logic false_car;
		logic link_chg;
		logic remote_fault_flag;
		logic lock_jab;
		logic link_good;
		logic irq_sel;
		logic irq_mask;
		logic [2:0] an_min;
		logic [2:0] an_max;
		logic [2:0] tone_div;
		logic tone_lvl;
		logic tone_out;
		logic irq;
		logic jab_off;
		logic pwr_keep;
		logic sleep_ok;
		logic enh_link;
		logic heartbeat;
		logic long_line;
		logic pol_fix;
		logic serial;
		logic no_lp;
	} pvcsr_regs_t;

endpackage : pvcsr_pkg

// ### logic/pvcsr_mdio_slave.sv
// Purpose: Serial management frame slave: decodes read and write frames on
//          the management clock and data pins and drives read data back.
// Assumes: Management clock well below a quarter of the system clock.
// Notes:   Frames need no preamble; a frame for another address is followed
//          to its end without driving the data pin.
`timescale 1ns/1ns
`include "pvcsr_params.svh"

module pvcsr_mdio_slave (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic mdc_i, // Management clock pin
	input wire logic mdio_i, // Management data pin, input side
	output logic mdio_o, // Management data pin, output side
	output logic mdio_oe_n_o, // Low while the data pin is driven
	output logic rd_stb_o, // One-cycle read request
	output logic wr_stb_o, // One-cycle write request
	output logic [4:0] addr_o, // Register address of the request
	output logic [15:0] wdata_o, // Write data
	input wire logic [15:0] rd_data_i // Read data, valid with rd_stb_o
);

	pvcsr_pkg::pvcsr_md_t st;
	pvcsr_pkg::pvcsr_md_t next_st;
	logic rise;
	logic bit_in;
	logic [9:0] addr_bits;

	assign rise = st.mdc_s2 & ~st.mdc_d;
	assign bit_in = st.mdio_s2;
	assign addr_bits = {st.shreg[8:0], bit_in};

	always_comb begin
		next_st = st;
		next_st.mdc_s1 = mdc_i;
		next_st.mdc_s2 = st.mdc_s1;
		next_st.mdc_d = st.mdc_s2;
		next_st.mdio_s1 = mdio_i;
		next_st.mdio_s2 = st.mdio_s1;
		next_st.rd_stb = 1'b0;
		next_st.wr_stb = 1'b0;
		// The register bank answers within one cycle, long before the next edge
		if (st.rd_stb) begin
			next_st.shreg = rd_data_i;
		end
		if (rise) begin
			case (st.state)
				pvcsr_pkg::MD_IDLE: begin
					if (!bit_in) begin
						next_st.state = pvcsr_pkg::MD_START;
					end
				end
				pvcsr_pkg::MD_START: begin
					next_st.cnt = 4'h0;
					next_st.state = bit_in ? pvcsr_pkg::MD_OP : pvcsr_pkg::MD_IDLE;
				end
				pvcsr_pkg::MD_OP: begin
					next_st.shreg = {st.shreg[14:0], bit_in};
					next_st.cnt = st.cnt + 4'h1;
					if (st.cnt == 4'h1) begin
						next_st.cnt = 4'h0;
						next_st.op_rd = ({st.shreg[0], bit_in} == `PVCSR_OP_READ);
						if (({st.shreg[0], bit_in} == `PVCSR_OP_READ) ||
							({st.shreg[0], bit_in} == `PVCSR_OP_WRITE)) begin
							next_st.state = pvcsr_pkg::MD_ADDR;
						end else begin
							next_st.state = pvcsr_pkg::MD_IDLE;
						end
					end
				end
				pvcsr_pkg::MD_ADDR: begin
					next_st.shreg = {st.shreg[14:0], bit_in};
					next_st.cnt = st.cnt + 4'h1;
					if (st.cnt == `PVCSR_ADDR_LAST) begin
						next_st.cnt = 4'h0;
						next_st.match = (addr_bits[9:5] == `PVCSR_PHY_ADDR);
						next_st.addr = addr_bits[4:0];
						next_st.rd_stb = st.op_rd & (addr_bits[9:5] == `PVCSR_PHY_ADDR);
						next_st.state = pvcsr_pkg::MD_TA;
					end
				end
				pvcsr_pkg::MD_TA: begin
					next_st.cnt = st.cnt + 4'h1;
					if (st.op_rd && st.match) begin
						next_st.mdio_out = 1'b0;
						next_st.oe_n = 1'b0;
					end
					if (st.cnt == `PVCSR_TA_LAST) begin
						next_st.cnt = 4'h0;
						next_st.state = pvcsr_pkg::MD_DATA;
						if (st.op_rd && st.match) begin
							next_st.mdio_out = st.shreg[15];
							next_st.shreg = {st.shreg[14:0], 1'b0};
						end
					end
				end
				pvcsr_pkg::MD_DATA: begin
					next_st.cnt = st.cnt + 4'h1;
					if (st.op_rd) begin
						next_st.mdio_out = st.shreg[15];
						next_st.shreg = {st.shreg[14:0], 1'b0};
					end else begin
						next_st.shreg = {st.shreg[14:0], bit_in};
					end
					if (st.cnt == `PVCSR_DATA_LAST) begin
						next_st.state = pvcsr_pkg::MD_IDLE;
						next_st.oe_n = 1'b1;
						next_st.mdio_out = 1'b1;
						next_st.wr_stb = ~st.op_rd & st.match;
						next_st.wdata = {st.shreg[14:0], bit_in};
					end
				end
				default: begin
					next_st.state = pvcsr_pkg::MD_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
			st.state <= pvcsr_pkg::MD_IDLE;
			st.mdio_out <= 1'b1;
			st.oe_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign mdio_o = st.mdio_out;
	assign mdio_oe_n_o = st.oe_n;
	assign rd_stb_o = st.rd_stb;
	assign wr_stb_o = st.wr_stb;
	assign addr_o = st.addr;
	assign wdata_o = st.wdata;

endmodule : pvcsr_mdio_slave

// ### logic/pvcsr_regs.sv
// Purpose: 10 Mbit/s control and quick-status management registers of the
//          embedded PHY, reached over the serial management pins.
// Assumes: Status inputs come from PHY core logic on the same clock; only
//          the management pins and the link-check pin are asynchronous.
// Notes:   Other register addresses read as zero and ignore writes.
// Behaviour
// - Tone bit with 10BASE-T powered sends a continuous 10 MHz square; resets zero.
// - Power-keep bit keeps 10BASE-T logic awake while link up; resets zero.
// - Jabber-guard-off bit disables receive jabber function; resets zero.
// - Enhanced link check active when register bit or external pin high.
// - Heartbeat bit enables heartbeat, only at 10 Mbit/s.
// - Long-line bit lowers squelch threshold, only at 10 Mbit/s.
// - At 10 Mbit/s, unless disabled, flag and correct a reversed pair.
// - Serial-select bit picks 10 Mbit/s serial mode; ignored at 100 Mbit/s.
// - No-link-pulse bit disables link pulses at 10 Mbit/s only.
// - Receive error at 100 Mbit/s sets a flag held until status read.
// - Source select zero: bit 14 holds false carrier at 100 Mbit/s until read.
// - Source select one: bit 14 flags any link-good change.
// - Remote fault sets a flag held until status read.
// - Bit 12 holds descrambler unlock at 100, jabber at 10, until read.
// - Link-good latches low on failure until read through management.
// - Read-only bit shows partner wants flow control exchange.
// - Read-only bits show negotiated speed and duplex.
// - Source select one: interrupt high only on link-change flag.
// - Interrupt-block bit high suppresses the interrupt entirely.
// - Field holds lowest autonegotiation state since last read; reads zero from reset until the first read.
// - Field holds highest autonegotiation state since last read.
`timescale 1ns/1ns
`include "pvcsr_params.svh"

module pvcsr_regs (
	input wire logic SYS_CLK_I, // System clock, 100 MHz
	input wire logic RESET_I, // Synchronous reset, active high
	input wire logic MDC_I, // Management clock pin
	input wire logic MDIO_I, // Management data pin, input side
	output logic MDIO_O, // Management data pin, output side
	output logic MDIO_OE_N_O, // Low while the data pin is driven
	input wire logic SPEED_100_I, // PHY runs at 100 Mbit/s
	input wire logic DUPLEX_FULL_I, // Negotiated full duplex
	input wire logic PARTNER_PAUSE_I, // Partner asks for flow control
	input wire logic LINK_UP_I, // Valid link present
	input wire logic RX_ERROR_I, // Receive error event
	input wire logic FALSE_CARRIER_I, // False carrier event
	input wire logic REMOTE_FAULT_I, // Remote fault event
	input wire logic DESCR_UNLOCK_I, // Descrambler lost lock event
	input wire logic JABBER_I, // Jabber condition event
	input wire logic [2:0] AN_STATE_I, // Current autonegotiation state code
	input wire logic POLARITY_REVERSED_I, // Pair found reversed
	input wire logic TENBT_POWERED_I, // 10BASE-T section powered
	input wire logic RX_ACTIVE_I, // Data being received
	input wire logic ENH_LINK_PIN_I, // External enhanced link check pin
	output logic TONE_O, // Continuous test tone
	output logic PHY_IRQ_O, // PHY interrupt, active high
	output logic JABBER_GUARD_OFF_O, // Jabber function disabled
	output logic RX_FULL_POWER_O, // Keep all 10BASE-T logic powered
	output logic SLEEP_OK_O, // Parts of 10BASE-T logic may power down
	output logic ENH_LINK_CHECK_O, // Enhanced link integrity test on
	output logic HEARTBEAT_ON_O, // Heartbeat enabled
	output logic LONG_LINE_SQUELCH_O, // Reduced squelch threshold
	output logic POLARITY_FIX_O, // Correct the reversed pair
	output logic POLARITY_REVERSED_FLAG_O, // Reversal seen and corrected
	output logic SERIAL_MODE_O, // 10 Mbit/s serial mode
	output logic NO_LINK_PULSE_O // Link pulses disabled
);

	pvcsr_pkg::pvcsr_regs_t st;
	pvcsr_pkg::pvcsr_regs_t next_st;
	logic rd_stb;
	logic wr_stb;
	logic [4:0] reg_addr;
	logic [15:0] wdata;
	logic [15:0] rd_data;
	logic [15:0] quick_word;
	logic rd_quick;
	logic wr_ten;
	logic wr_quick;
	logic tone_run;
	logic ten_mode;

	// Hardware set takes precedence over the clear of a read
	function automatic logic sticky(input logic flag, input logic clr, input logic set);
		sticky = (flag & ~clr) | set;
	endfunction : sticky

	pvcsr_mdio_slave pvcsr_mdio_slave_inst (
		.clk_i(SYS_CLK_I),
		.rst_i(RESET_I),
		.mdc_i(MDC_I),
		.mdio_i(MDIO_I),
		.mdio_o(MDIO_O),
		.mdio_oe_n_o(MDIO_OE_N_O),
		.rd_stb_o(rd_stb),
		.wr_stb_o(wr_stb),
		.addr_o(reg_addr),
		.wdata_o(wdata),
		.rd_data_i(rd_data)
	);

	assign rd_quick = rd_stb & (reg_addr == `PVCSR_REG_QUICK);
	assign wr_ten = wr_stb & (reg_addr == `PVCSR_REG_TEN_MEG);
	assign wr_quick = wr_stb & (reg_addr == `PVCSR_REG_QUICK);
	assign tone_run = st.ctl[`PVCSR_CTL_TONE] & TENBT_POWERED_I;
	assign ten_mode = ~SPEED_100_I;

	assign quick_word = {st.rx_err,
		st.irq_sel ? st.link_chg : st.false_car,
		st.remote_fault_flag, st.lock_jab, st.link_good,
		PARTNER_PAUSE_I, SPEED_100_I, DUPLEX_FULL_I,
		st.irq_sel, st.irq_mask, st.an_min, st.an_max};

	always_comb begin
		if (reg_addr == `PVCSR_REG_TEN_MEG) begin
			rd_data = st.ctl;
		end else if (reg_addr == `PVCSR_REG_QUICK) begin
			rd_data = quick_word;
		end else begin
			rd_data = 16'h0000;
		end
	end

	always_comb begin
		next_st = st;
		next_st.enh_sync = {st.enh_sync[0], ENH_LINK_PIN_I};
		if (wr_ten) begin
			next_st.ctl = wdata & `PVCSR_CTL_WMASK;
		end
		if (wr_quick) begin
			next_st.irq_sel = wdata[`PVCSR_QS_IRQ_SEL];
			next_st.irq_mask = wdata[`PVCSR_QS_IRQ_MASK];
		end
		next_st.rx_err = sticky(st.rx_err, rd_quick, RX_ERROR_I & SPEED_100_I);
		next_st.false_car = sticky(st.false_car, rd_quick, FALSE_CARRIER_I & SPEED_100_I);
		next_st.remote_fault_flag = sticky(st.remote_fault_flag, rd_quick, REMOTE_FAULT_I);
		next_st.lock_jab = sticky(st.lock_jab, rd_quick,
			SPEED_100_I ? DESCR_UNLOCK_I : JABBER_I);
		// A read reloads the live link level; a failure in that cycle still wins
		next_st.link_good = (rd_quick | st.link_good) & LINK_UP_I;
		next_st.link_chg = sticky(st.link_chg, rd_quick,
			next_st.link_good != st.link_good);
		if (rd_quick) begin
			next_st.an_min = AN_STATE_I;
			next_st.an_max = AN_STATE_I;
		end else begin
			next_st.an_min = (AN_STATE_I < st.an_min) ? AN_STATE_I : st.an_min;
			next_st.an_max = (AN_STATE_I > st.an_max) ? AN_STATE_I : st.an_max;
		end
		if (st.tone_div == 3'(`PVCSR_TONE_HALF_CYC - 1)) begin
			next_st.tone_div = 3'h0;
			next_st.tone_lvl = ~st.tone_lvl;
		end else begin
			next_st.tone_div = st.tone_div + 3'h1;
		end
		next_st.tone_out = tone_run & next_st.tone_lvl;
		if (st.irq_sel) begin
			next_st.irq = ~st.irq_mask & st.link_chg;
		end else begin
			next_st.irq = ~st.irq_mask & (st.rx_err | st.false_car | st.remote_fault_flag |
				st.lock_jab | ~st.link_good);
		end
		next_st.jab_off = st.ctl[`PVCSR_CTL_JAB_OFF];
		next_st.pwr_keep = st.ctl[`PVCSR_CTL_PWR_KEEP] & LINK_UP_I;
		next_st.sleep_ok = ~RX_ACTIVE_I & ~(st.ctl[`PVCSR_CTL_PWR_KEEP] & LINK_UP_I);
		next_st.enh_link = st.ctl[`PVCSR_CTL_ENH_LINK] | st.enh_sync[1];
		next_st.heartbeat = st.ctl[`PVCSR_CTL_HEARTBEAT] & ten_mode;
		next_st.long_line = st.ctl[`PVCSR_CTL_LONG_LINE] & ten_mode;
		next_st.pol_fix = ~st.ctl[`PVCSR_CTL_POL_OFF] & ten_mode & POLARITY_REVERSED_I;
		next_st.serial = st.ctl[`PVCSR_CTL_SERIAL] & ten_mode;
		next_st.no_lp = st.ctl[`PVCSR_CTL_NO_LP] & ten_mode;
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			st <= '0;
			st.ctl <= `PVCSR_CTL_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign TONE_O = st.tone_out;
	assign PHY_IRQ_O = st.irq;
	assign JABBER_GUARD_OFF_O = st.jab_off;
	assign RX_FULL_POWER_O = st.pwr_keep;
	assign SLEEP_OK_O = st.sleep_ok;
	assign ENH_LINK_CHECK_O = st.enh_link;
	assign HEARTBEAT_ON_O = st.heartbeat;
	assign LONG_LINE_SQUELCH_O = st.long_line;
	assign POLARITY_FIX_O = st.pol_fix;
	assign POLARITY_REVERSED_FLAG_O = st.pol_fix;
	assign SERIAL_MODE_O = st.serial;
	assign NO_LINK_PULSE_O = st.no_lp;

	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (RESET_I);

	sequence s_tone_run;
		tone_run [*7];
	endsequence

	sequence s_flag_kept(flag);
		flag ##1 flag;
	endsequence

	property p_tone_period;
		s_tone_run |-> (TONE_O != $past(TONE_O, 5));
	endproperty
	a_tone_period: assert property (p_tone_period) else $error("tone half period wrong");

	property p_rx_err_hold;
		(RX_ERROR_I && SPEED_100_I) ##1 !rd_quick |=> st.rx_err;
	endproperty
	a_rx_err_hold: assert property (p_rx_err_hold) else $error("rx error flag lost");

	property p_read_clears;
		(rd_quick && !RX_ERROR_I) |=> !st.rx_err;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("rx error not cleared");

	property p_link_latch_low;
		!LINK_UP_I ##1 !rd_quick |=> !st.link_good;
	endproperty
	a_link_latch_low: assert property (p_link_latch_low) else $error("link not latched low");

	property p_link_change;
		(st.link_good != $past(st.link_good)) |-> st.link_chg;
	endproperty
	a_link_change: assert property (p_link_change) else $error("link change missed");

	property p_irq_mode0;
		(!st.irq_sel && !st.irq_mask && !st.link_good) |=> PHY_IRQ_O;
	endproperty
	a_irq_mode0: assert property (p_irq_mode0) else $error("irq missing on link low");

	property p_irq_mode1;
		(st.irq_sel && !st.irq_mask) |=> (PHY_IRQ_O == $past(st.link_chg));
	endproperty
	a_irq_mode1: assert property (p_irq_mode1) else $error("irq not link change only");

	property p_irq_block;
		s_flag_kept(st.irq_mask) |=> !PHY_IRQ_O [*1];
	endproperty
	a_irq_block: assert property (p_irq_block) else $error("irq while blocked");

	property p_an_min;
		!rd_quick |=> (st.an_min <= $past(st.an_min)) && (st.an_min <= $past(AN_STATE_I));
	endproperty
	a_an_min: assert property (p_an_min) else $error("lowest state wrong");

	property p_an_max;
		!rd_quick |=> (st.an_max >= $past(st.an_max)) && (st.an_max >= $past(AN_STATE_I));
	endproperty
	a_an_max: assert property (p_an_max) else $error("highest state wrong");

	property p_unused_zero;
		(st.ctl[12:7] == 6'h00) && !st.ctl[2];
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused control bit set");

	property p_serial_fast;
		SPEED_100_I |=> !SERIAL_MODE_O && !NO_LINK_PULSE_O && !HEARTBEAT_ON_O;
	endproperty
	a_serial_fast: assert property (p_serial_fast) else $error("10M control at 100M");

	property p_false_car_hold;
		(FALSE_CARRIER_I && SPEED_100_I) ##1 !rd_quick |=> st.false_car;
	endproperty
	a_false_car_hold: assert property (p_false_car_hold) else $error("false carrier lost");

	property p_remote_fault_flag_hold;
		REMOTE_FAULT_I ##1 !rd_quick |=> st.remote_fault_flag;
	endproperty
	a_remote_fault_flag_hold: assert property (p_remote_fault_flag_hold) else $error("remote fault lost");

	property p_lock_jab_hold;
		(SPEED_100_I ? DESCR_UNLOCK_I : JABBER_I) ##1 !rd_quick |=> st.lock_jab;
	endproperty
	a_lock_jab_hold: assert property (p_lock_jab_hold) else $error("bit 12 flag lost");

	property p_set_wins;
		(rd_quick && REMOTE_FAULT_I) |=> st.remote_fault_flag;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost in read cycle");

	property p_irq_flags;
		(!st.irq_sel && !st.irq_mask && (st.rx_err || st.false_car || st.remote_fault_flag ||
			st.lock_jab)) |=> PHY_IRQ_O;
	endproperty
	a_irq_flags: assert property (p_irq_flags) else $error("irq missing on flag");

	property p_tone_off;
		!tone_run |=> !TONE_O;
	endproperty
	a_tone_off: assert property (p_tone_off) else $error("tone while not enabled");

	property p_pwr_keep;
		(st.ctl[`PVCSR_CTL_PWR_KEEP] && LINK_UP_I) |=> (RX_FULL_POWER_O && !SLEEP_OK_O);
	endproperty
	a_pwr_keep: assert property (p_pwr_keep) else $error("power keep not applied");

	property p_pol_off;
		st.ctl[`PVCSR_CTL_POL_OFF] |=> !POLARITY_FIX_O;
	endproperty
	a_pol_off: assert property (p_pol_off) else $error("polarity fixed while off");

endmodule : pvcsr_regs

// ### testbench/pvcsr_station.sv
// Purpose: Management station model: drives read and write frames on the
//          management clock and data pins and samples read data.
// Assumes: Called as station_inst.frame from the bench, at a clock edge.
// Notes:   Clock stands low between frames; half is the MDC half period
//          in system cycles and may be raised to model a slow station.
`timescale 1ns/1ns

module pvcsr_station (
	input wire logic clk_i, // System clock
	output logic mdc_o, // Management clock, still outside frames
	output logic drv_o, // Value the station puts on the data pin
	output logic drv_en_o, // High while the station drives the data pin
	input wire logic mdio_i // Resolved data pin
);
	int half = 6;

	initial begin
		mdc_o = 1'b0;
		drv_o = 1'b1;
		drv_en_o = 1'b0;
	end

	// Data changes with the falling clock and is sampled at the rising one
	task automatic bit_cyc(input logic en, input logic val, output logic smp);
		drv_en_o <= en;
		drv_o <= val;
		repeat (half) @(posedge clk_i);
		smp = mdio_i;
		mdc_o <= 1'b1;
		repeat (half) @(posedge clk_i);
		mdc_o <= 1'b0;
	endtask : bit_cyc

	task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
			input logic [15:0] wd, output logic [15:0] rdat);
		logic [31:0] hdr;
		logic s;
		hdr = {16'hFFFF, 2'h1, (rd ? 2'h2 : 2'h1), phy, ra, 2'h2};
		@(posedge clk_i);
		for (int i = 31; i >= 0; i--) begin
			bit_cyc(!(rd && i < 2), hdr[i], s);
		end
		for (int i = 15; i >= 0; i--) begin
			bit_cyc(!rd, wd[i], s);
			rdat[i] = s;
		end
		drv_en_o <= 1'b0;
	endtask : frame
endmodule : pvcsr_station

// ### testbench/pvcsr_regs_test.sv
// Purpose: Self-checking bench of the management register bank.
// Assumes: Data pin has a pull-up; nobody driving reads as one.
// Notes:   Control register rows run from a table, status cases by hand.
`timescale 1ns/1ns
`include "pvcsr_params.svh"

module pvcsr_regs_test;
	typedef struct packed {
		logic [15:0] w;
		logic spd;
		logic [15:0] rb;
		logic [9:0] outs;
	} pvcsr_row_t;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic speed = 1'b1;
	logic duplex = 1'b1;
	logic pause = 1'b1;
	logic link = 1'b1;
	logic [4:0] ev = 5'h00;
	logic [2:0] an = 3'h3;
	logic polrev = 1'b1;
	logic tpow = 1'b0;
	logic rxact = 1'b0;
	logic enh_pin = 1'b0;
	wire mdc, drv, drv_en, mdio_o, oe_n, tone, irq, mdio_w;
	wire [9:0] outs;
	int fails = 0;
	int num_checks = 0;
	pvcsr_row_t rows [5] = '{
		'{16'hFFFF, 1'b0, 16'hE07B, 10'h373},
		'{16'hFFFF, 1'b1, 16'hE07B, 10'h340},
		'{16'h0000, 1'b0, 16'h0000, 10'h08C},
		'{16'h1F84, 1'b0, 16'h0000, 10'h08C},
		'{16'h0000, 1'b1, 16'h0000, 10'h080}};

	assign mdio_w = !oe_n ? mdio_o : (drv_en ? drv : 1'b1);

	always #5 clk = ~clk;

	pvcsr_station station_inst (.clk_i(clk), .mdc_o(mdc), .drv_o(drv), .drv_en_o(drv_en),
		.mdio_i(mdio_w));

	pvcsr_regs pvcsr_regs_inst (.SYS_CLK_I(clk), .RESET_I(rst), .MDC_I(mdc), .MDIO_I(mdio_w),
		.MDIO_O(mdio_o), .MDIO_OE_N_O(oe_n), .SPEED_100_I(speed), .DUPLEX_FULL_I(duplex),
		.PARTNER_PAUSE_I(pause), .LINK_UP_I(link), .RX_ERROR_I(ev[4]),
		.FALSE_CARRIER_I(ev[3]), .REMOTE_FAULT_I(ev[2]), .DESCR_UNLOCK_I(ev[1]),
		.JABBER_I(ev[0]), .AN_STATE_I(an), .POLARITY_REVERSED_I(polrev),
		.TENBT_POWERED_I(tpow), .RX_ACTIVE_I(rxact), .ENH_LINK_PIN_I(enh_pin),
		.TONE_O(tone), .PHY_IRQ_O(irq), .JABBER_GUARD_OFF_O(outs[9]),
		.RX_FULL_POWER_O(outs[8]), .SLEEP_OK_O(outs[7]), .ENH_LINK_CHECK_O(outs[6]),
		.HEARTBEAT_ON_O(outs[5]), .LONG_LINE_SQUELCH_O(outs[4]), .POLARITY_FIX_O(outs[3]),
		.POLARITY_REVERSED_FLAG_O(outs[2]), .SERIAL_MODE_O(outs[1]),
		.NO_LINK_PULSE_O(outs[0]));

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic rd(input logic [4:0] ra, output logic [15:0] d);
		station_inst.frame(1'b1, `PVCSR_PHY_ADDR, ra, 16'h0000, d);
	endtask : rd

	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		logic [15:0] junk;
		station_inst.frame(1'b0, `PVCSR_PHY_ADDR, ra, d, junk);
		repeat (10) @(posedge clk);
	endtask : wr

	// One-cycle events; optionally the link drops for the same cycle
	task automatic pulse(input logic [4:0] v, input logic drop);
		@(posedge clk);
		ev <= v;
		link <= !drop;
		@(posedge clk);
		ev <= 5'h00;
		link <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : pulse

	task automatic report_and_stop();
		if (fails == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		// Whole sequence needs about 18000 cycles
		repeat (40000) @(posedge clk);
		fails++;
		report_and_stop();
	end

	initial begin
		logic [15:0] d;
		int highs;
		int edges;
		logic prev;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check("oe_n after reset", {15'h0000, oe_n}, 16'h0001);
		repeat (4) @(posedge clk);
		check("irq link low", {15'h0000, irq}, 16'h0001);
		rd(`PVCSR_REG_TEN_MEG, d);
		check("control reset", d, 16'h0000);
		rd(`PVCSR_REG_QUICK, d);
		check("status first", d, 16'h0703);
		foreach (rows[i]) begin
			speed <= rows[i].spd;
			wr(`PVCSR_REG_TEN_MEG, rows[i].w);
			rd(`PVCSR_REG_TEN_MEG, d);
			check("control readback", d, rows[i].rb);
			check("control outputs", {6'h00, outs}, {6'h00, rows[i].outs});
		end
		// Autonegotiation low and high marks since the last read
		speed <= 1'b1;
		an <= 3'h5;
		repeat (3) @(posedge clk);
		an <= 3'h1;
		repeat (3) @(posedge clk);
		an <= 3'h5;
		repeat (3) @(posedge clk);
		check("irq idle", {15'h0000, irq}, 16'h0000);
		rd(`PVCSR_REG_QUICK, d);
		check("status marks", d, 16'h0F0D);
		pulse(5'h1E, 1'b0);
		check("irq on flags", {15'h0000, irq}, 16'h0001);
		rd(`PVCSR_REG_QUICK, d);
		check("status flags", d, 16'hFF2D);
		rd(`PVCSR_REG_QUICK, d);
		check("status cleared", d, 16'h0F2D);
		repeat (3) @(posedge clk);
		check("irq cleared", {15'h0000, irq}, 16'h0000);
		// Masked: jabber at 10 Mbit/s and a link drop raise nothing
		speed <= 1'b0;
		wr(`PVCSR_REG_QUICK, 16'h0040);
		pulse(5'h01, 1'b1);
		check("irq masked", {15'h0000, irq}, 16'h0000);
		rd(`PVCSR_REG_QUICK, d);
		check("status masked", d, 16'h156D);
		// Link-change source: only a link transition interrupts
		wr(`PVCSR_REG_QUICK, 16'h0080);
		rd(`PVCSR_REG_QUICK, d);
		check("irq quiet", {15'h0000, irq}, 16'h0000);
		pulse(5'h00, 1'b1);
		check("irq link change", {15'h0000, irq}, 16'h0001);
		rd(`PVCSR_REG_QUICK, d);
		check("status link change", d, 16'h45AD);
		// Refusals: other address, other register, slow station
		station_inst.frame(1'b1, 5'h01, `PVCSR_REG_TEN_MEG, 16'h0000, d);
		check("foreign read", d, 16'hFFFF);
		station_inst.frame(1'b0, 5'h01, `PVCSR_REG_TEN_MEG, 16'hFFFF, d);
		station_inst.half = 20;
		rd(`PVCSR_REG_TEN_MEG, d);
		check("foreign write", d, 16'h0000);
		rd(5'h05, d);
		check("unmapped read", d, 16'h0000);
		station_inst.half = 6;
		enh_pin <= 1'b1;
		repeat (10) @(posedge clk);
		check("link check pin", {15'h0000, outs[6]}, 16'h0001);
		// Tone: 5 cycles high, 5 low while powered
		tpow <= 1'b1;
		wr(`PVCSR_REG_TEN_MEG, 16'h8000);
		highs = 0;
		edges = 0;
		// Sampled mid-cycle, away from the edge that moves the tone
		@(negedge clk);
		prev = tone;
		for (int i = 0; i < 100; i++) begin
			@(negedge clk);
			highs += int'(tone === 1'b1);
			edges += int'(tone === 1'b1 && prev === 1'b0);
			prev = tone;
		end
		check("tone highs", 16'(highs), 16'h0032);
		check("tone periods", 16'(edges), 16'h000A);
		@(posedge clk);
		tpow <= 1'b0;
		rxact <= 1'b1;
		pause <= 1'b0;
		duplex <= 1'b0;
		repeat (4) @(posedge clk);
		check("tone unpowered", {15'h0000, tone}, 16'h0000);
		check("sleep while receiving", {15'h0000, outs[7]}, 16'h0000);
		rd(`PVCSR_REG_QUICK, d);
		check("status pause duplex", d, 16'h48AD);
		report_and_stop();
	end
endmodule : pvcsr_regs_test
